// ==== common/wrs_params.svh ====
// constants and overview for the wait-on-reservation stall controller
//
// Overview of operation
// - the no-timeout wait holds the hart stalled in low power until the reservation breaks or an interrupt shows.
// - any stall lasts only while the reservation is valid and no interrupt is pending, enabled or not.
// - the short-timeout wait also ends its stall once a fixed short time has passed.
// - both waits run in every privilege mode, trapping only under the timeout-wait conditions.
// - the hart may end a stall early for reasons of its own and complete the wait.
// - waking on a pending interrupt follows the wait-for-interrupt resume rules.
// - with the machine trap bit set, a no-timeout wait outside machine mode that overruns raises illegal instruction.
// - in virtual modes with only the virtual trap bit set, an overrunning no-timeout wait raises virtual instruction.
// - with the machine trap bit clear, a user-mode no-timeout wait never raises illegal instruction.
// - the short timeout is about ten to one hundred cache-miss latencies.
`ifndef WRS_PARAMS_SVH
`define WRS_PARAMS_SVH

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define WRS_CLK_PERIOD_PS   5000
`define WRS_SHORT_TIME_NS   1000
`define WRS_SHORT_CYCLES    ((`WRS_SHORT_TIME_NS * 1000) / `WRS_CLK_PERIOD_PS)
`define WRS_TRAP_TIME_NS    4000
`define WRS_TRAP_CYCLES     ((`WRS_TRAP_TIME_NS * 1000) / `WRS_CLK_PERIOD_PS)
`define WRS_CNT_W           12
`define WRS_CNT_ZERO        12'h000
`define WRS_CNT_ONE         12'h001

// -----------------------------------------------------------------------------
// privilege encodings
// -----------------------------------------------------------------------------
`define WRS_PRIV_U          2'h0
`define WRS_PRIV_S          2'h1
`define WRS_PRIV_M          2'h3

`endif

// ==== common/wrs_pkg.sv ====
// types for the wait-on-reservation stall controller
package wrs_pkg;

  typedef enum logic [2:0] {
    WRS_IDLE  = 3'h1,
    WRS_STALL = 3'h2,
    WRS_DONE  = 3'h4
  } wrs_state_e;

  typedef struct packed {
    logic       valid;
    logic       no_timeout;
    logic [1:0] priv;
    logic       virt;
  } wrs_issue_s;

  typedef struct packed {
    logic machine_timeout_wait_trap;
    logic virtual_timeout_wait_trap;
  } wrs_trap_cfg_s;

  typedef struct packed {
    logic retire;
    logic illegal_instr;
    logic virtual_instr;
  } wrs_result_s;

endpackage : wrs_pkg

// ==== src/wrs_stall_ctrl.sv ====
// stall controller for the two wait-on-reservation instructions
`timescale 1ns/1ps
`default_nettype none
`include "wrs_params.svh"

module wrs_stall_ctrl (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire wrs_pkg::wrs_issue_s    issue_i,
  input  wire wrs_pkg::wrs_trap_cfg_s trap_cfg_i,
  input  wire logic                   resv_valid_i,
  input  wire logic                   irq_pending_i,
  input  wire logic                   early_exit_i,
  output logic                        stall_o,
  output logic                        low_power_o,
  output wrs_pkg::wrs_result_s        result_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  wrs_pkg::wrs_state_e  state_r;
  wrs_pkg::wrs_state_e  state_nxt;
  logic                 nto_r;
  logic                 trap_m_r;
  logic                 trap_v_r;
  logic                 sto_expired;
  logic                 trap_expired;
  logic                 wake;
  logic                 trap_fire;
  wrs_pkg::wrs_result_s result_nxt;
  wrs_pkg::wrs_result_s result_r;

  localparam logic [`WRS_CNT_W-1:0] STO_LOAD  = `WRS_CNT_W'(`WRS_SHORT_CYCLES);
  localparam logic [`WRS_CNT_W-1:0] TRAP_LOAD = `WRS_CNT_W'(`WRS_TRAP_CYCLES);

  wire start = issue_i.valid && (state_r == wrs_pkg::WRS_IDLE);

  // ---------------------------------------------------------------------------
  // trap eligibility, latched at issue
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nto_r    <= 1'b0;
      trap_m_r <= 1'b0;
      trap_v_r <= 1'b0;
    end else if (start) begin
      nto_r    <= issue_i.no_timeout;
      // machine mode never traps; non-virtual user mode only via the machine bit
      trap_m_r <= issue_i.no_timeout && trap_cfg_i.machine_timeout_wait_trap
                  && (issue_i.priv != `WRS_PRIV_M);
      trap_v_r <= issue_i.no_timeout && issue_i.virt
                  && trap_cfg_i.virtual_timeout_wait_trap
                  && !trap_cfg_i.machine_timeout_wait_trap;
    end
  end

  // ---------------------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------------------
  // short timeout ~1 us: tens of cache-miss latencies at typical memory delay
  wrs_timer u_sto_timer (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (start),
    .run_i     ((state_r == wrs_pkg::WRS_STALL) && !nto_r),
    .load_i    (STO_LOAD),
    .expired_o (sto_expired)
  );

  wrs_timer u_trap_timer (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (start),
    .run_i     ((state_r == wrs_pkg::WRS_STALL) && (trap_m_r || trap_v_r)),
    .load_i    (TRAP_LOAD),
    .expired_o (trap_expired)
  );

  // ---------------------------------------------------------------------------
  // stall machine
  // ---------------------------------------------------------------------------
  // pending interrupt wakes regardless of enable, as for wait-for-interrupt
  assign wake      = !resv_valid_i || irq_pending_i || early_exit_i
                     || sto_expired;
  // a normal wake in the same cycle beats the trap: the wait did complete
  assign trap_fire = trap_expired && !wake;

  always_comb begin
    state_nxt  = state_r;
    result_nxt = '0;
    unique case (state_r)
      wrs_pkg::WRS_IDLE: begin
        if (issue_i.valid) begin
          state_nxt = wrs_pkg::WRS_STALL;
        end
      end
      wrs_pkg::WRS_STALL: begin
        if (wake) begin
          state_nxt         = wrs_pkg::WRS_DONE;
          result_nxt.retire = 1'b1;
        end else if (trap_fire) begin
          state_nxt                = wrs_pkg::WRS_DONE;
          result_nxt.illegal_instr = trap_m_r;
          result_nxt.virtual_instr = trap_v_r && !trap_m_r;
        end
      end
      wrs_pkg::WRS_DONE: begin
        state_nxt = wrs_pkg::WRS_IDLE;
      end
      default: begin
        state_nxt = wrs_pkg::WRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= wrs_pkg::WRS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result_r <= '0;
    end else begin
      result_r <= result_nxt;
    end
  end

  // hold the pipeline from the issue cycle through the last stall cycle
  assign stall_o     = (state_r == wrs_pkg::WRS_STALL) || issue_i.valid
                       && (state_r == wrs_pkg::WRS_IDLE);
  assign low_power_o = (state_r == wrs_pkg::WRS_STALL);
  assign result_o    = result_r;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_stalled;
    state_r == wrs_pkg::WRS_STALL;
  endsequence

  property p_resv_lost;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_stalled and !resv_valid_i |=> result_o.retire ##1 !low_power_o;
  endproperty
  a_resv_lost: assert property (p_resv_lost) else $error("stall kept after reservation loss");

  property p_irq_wake;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_stalled and irq_pending_i |=> result_o.retire && !result_o.illegal_instr;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("pending interrupt did not wake");

  property p_sto_bound;
    @(posedge clk_i) disable iff (!rst_n_i)
      start && !issue_i.no_timeout |-> ##[1:201] !low_power_o;
  endproperty
  a_sto_bound: assert property (p_sto_bound) else $error("short timeout overran");

  property p_issue_stalls;
    @(posedge clk_i) disable iff (!rst_n_i)
      start |=> low_power_o;
  endproperty
  a_issue_stalls: assert property (p_issue_stalls) else $error("wait did not enter stall");

  property p_no_m_trap;
    @(posedge clk_i) disable iff (!rst_n_i)
      start && issue_i.priv == `WRS_PRIV_M |=> !trap_m_r && !trap_v_r;
  endproperty
  a_no_m_trap: assert property (p_no_m_trap) else $error("machine mode wait armed trap");

  property p_user_no_illegal;
    @(posedge clk_i) disable iff (!rst_n_i)
      start && !trap_cfg_i.machine_timeout_wait_trap |=> !trap_m_r;
  endproperty
  a_user_no_illegal: assert property (p_user_no_illegal) else $error("illegal trap armed");

  property p_illegal_cause;
    @(posedge clk_i) disable iff (!rst_n_i)
      result_o.illegal_instr |-> $past(trap_expired) && !result_o.retire
                                 && !result_o.virtual_instr;
  endproperty
  a_illegal_cause: assert property (p_illegal_cause) else $error("illegal trap without timeout");

  property p_virt_cause;
    @(posedge clk_i) disable iff (!rst_n_i)
      result_o.virtual_instr |-> $past(trap_v_r) && !$past(trap_m_r);
  endproperty
  a_virt_cause: assert property (p_virt_cause) else $error("virtual trap wrongly raised");

  property p_early_exit;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_stalled and early_exit_i |=> result_o.retire;
  endproperty
  a_early_exit: assert property (p_early_exit) else $error("early exit ignored");

  property p_retire_pulse;
    @(posedge clk_i) disable iff (!rst_n_i)
      result_o.retire |=> !result_o.retire && !low_power_o;
  endproperty
  a_retire_pulse: assert property (p_retire_pulse) else $error("retire not a single pulse");

endmodule : wrs_stall_ctrl
`default_nettype wire

// ==== src/wrs_timer.sv ====
// down-counter that flags when a loaded interval has elapsed
`timescale 1ns/1ps
`default_nettype none
`include "wrs_params.svh"

module wrs_timer (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  start_i,
  input  wire logic                  run_i,
  input  wire logic [`WRS_CNT_W-1:0] load_i,
  output logic                       expired_o
);

  logic [`WRS_CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= `WRS_CNT_ZERO;
    end else if (start_i) begin
      cnt_r <= load_i;
    end else if (run_i && cnt_r != `WRS_CNT_ZERO) begin
      cnt_r <= cnt_r - `WRS_CNT_ONE;
    end
  end

  assign expired_o = run_i && (cnt_r == `WRS_CNT_ONE);

endmodule : wrs_timer
`default_nettype wire

// ==== test/wrs_hart_model.sv ====
// hart-side partner: reservation tracker, interrupt source, early-exit wish
`timescale 1ns/1ps
`default_nettype none

module wrs_hart_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [9:0] delay_i,
  output logic            resv_valid_o,
  output logic            irq_pending_o,
  output logic            early_exit_o
);
  // ---------------------------------------------------------------------------
  // event scheduler
  // ---------------------------------------------------------------------------
  logic [9:0] cnt_r;
  logic       armed_r;

  // a wait is only started with a fresh reservation, never inside an lr/sc loop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r         <= 10'h000;
      armed_r       <= 1'b0;
      resv_valid_o  <= 1'b1;
      irq_pending_o <= 1'b0;
      early_exit_o  <= 1'b0;
    end else if (start_i) begin
      cnt_r         <= delay_i;
      armed_r       <= 1'b1;
      resv_valid_o  <= 1'b1;
      irq_pending_o <= 1'b0;
      early_exit_o  <= 1'b0;
    end else if (armed_r && cnt_r != 10'h000) begin
      cnt_r <= cnt_r - 10'h001;
    end else if (armed_r) begin
      armed_r <= 1'b0;
      // mode 3 holds the reservation for ever
      case (mode_i)
        2'h0: resv_valid_o <= 1'b0;
        2'h1: irq_pending_o <= 1'b1;
        2'h2: early_exit_o <= 1'b1;
        default: ;
      endcase
    end
  end
endmodule : wrs_hart_model

`default_nettype wire

// ==== test/wrs_stall_ctrl_tb_top.sv ====
// self-checking bench for the wait-on-reservation stall controller
`timescale 1ns/1ps
`default_nettype none
`include "wrs_params.svh"

module wrs_stall_ctrl_tb_top;
  // ---------------------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------------------
  localparam wrs_pkg::wrs_result_s RET = 3'h4;
  localparam wrs_pkg::wrs_result_s ILL = 3'h2;
  localparam wrs_pkg::wrs_result_s VIR = 3'h1;
  logic                  clk_i;
  logic                  rst_n_i;
  wrs_pkg::wrs_issue_s   issue;
  wrs_pkg::wrs_trap_cfg_s cfg;
  logic                  start;
  logic [1:0]            mode;
  logic [9:0]            delay;
  logic                  resv;
  logic                  irq;
  logic                  early;
  logic                  stall;
  logic                  low_power;
  wrs_pkg::wrs_result_s  result;
  int                    fail_count;
  int                    comparisons;

  wrs_stall_ctrl u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .issue_i(issue), .trap_cfg_i(cfg),
    .resv_valid_i(resv), .irq_pending_i(irq), .early_exit_i(early), .stall_o(stall),
    .low_power_o(low_power), .result_o(result));
  wrs_hart_model u_hart (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start), .mode_i(mode),
    .delay_i(delay), .resv_valid_o(resv), .irq_pending_o(irq), .early_exit_o(early));

  // ---------------------------------------------------------------------------
  // compare and closing tasks
  // ---------------------------------------------------------------------------
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_res(input wrs_pkg::wrs_result_s exp, input wrs_pkg::wrs_result_s got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH result expected %b seen %b", exp, got);
    end
  endtask : check_res

  task automatic check_range(input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("MISMATCH latency expected %0d..%0d seen %0d", lo, hi, got);
    end
  endtask : check_range

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // one wait: issue, let the partner act after d cycles, judge outcome and latency
  task automatic run_wait(input string name, input logic nto, input logic [1:0] priv,
    input logic virt, input logic mbit, input logic vbit, input logic [1:0] how,
    input logic [9:0] d, input wrs_pkg::wrs_result_s exp, input int lo, input int hi);
    int n;
    n = 1;
    @(posedge clk_i);
    issue <= '{1'b1, nto, priv, virt};
    cfg   <= '{mbit, vbit};
    mode  <= how;
    delay <= d;
    start <= 1'b1;
    #1;
    check_bit("stall", 1'b1, stall);
    check_bit("low_power", 1'b0, low_power);
    @(posedge clk_i);
    issue.valid <= 1'b0;
    start       <= 1'b0;
    #1;
    check_bit("low_power", 1'b1, low_power);
    check_bit("stall", 1'b1, stall);
    while (result === 3'h0 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check_res(exp, result);
    check_bit("low_power", 1'b0, low_power);
    check_range(lo, hi, n);
    @(posedge clk_i);
    #1;
    check_res(3'h0, result);
    @(posedge clk_i);
    #1;
    check_bit("stall", 1'b0, stall);
    $display("test %s done", name);
  endtask : run_wait

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_resv_break;
    run_wait("resv_break", 1, `WRS_PRIV_U, 0, 0, 0, 0, 5, RET, 6, 10);
  endtask : t_resv_break

  task automatic t_irq_wake;
    run_wait("irq_wake", 1, `WRS_PRIV_S, 0, 0, 0, 1, 3, RET, 4, 8);
  endtask : t_irq_wake

  task automatic t_early_exit;
    run_wait("early_exit", 0, `WRS_PRIV_U, 0, 0, 0, 2, 4, RET, 5, 9);
  endtask : t_early_exit

  task automatic t_short_timeout;
    // machine bit set: the short wait must still just time out and retire
    run_wait("short_timeout", 0, `WRS_PRIV_U, 0, 1, 0, 3, 0, RET,
      `WRS_SHORT_CYCLES - 1, `WRS_SHORT_CYCLES + 4);
  endtask : t_short_timeout

  task automatic t_trap_priority;
    // both trap bits set in virtual supervisor: the machine bit wins
    run_wait("trap_priority", 1, `WRS_PRIV_S, 1, 1, 1, 3, 0, ILL,
      `WRS_TRAP_CYCLES - 1, `WRS_TRAP_CYCLES + 4);
  endtask : t_trap_priority

  task automatic t_trap_machine;
    run_wait("trap_machine", 1, `WRS_PRIV_U, 0, 1, 0, 3, 0, ILL,
      `WRS_TRAP_CYCLES - 1, `WRS_TRAP_CYCLES + 4);
  endtask : t_trap_machine

  task automatic t_trap_virtual;
    run_wait("trap_virtual", 1, `WRS_PRIV_U, 1, 0, 1, 3, 0, VIR,
      `WRS_TRAP_CYCLES - 1, `WRS_TRAP_CYCLES + 4);
  endtask : t_trap_virtual

  task automatic t_machine_mode;
    run_wait("machine_mode", 1, `WRS_PRIV_M, 0, 1, 0, 0, 900, RET, 901, 905);
  endtask : t_machine_mode

  task automatic t_user_no_trap;
    run_wait("user_no_trap", 1, `WRS_PRIV_U, 0, 0, 0, 0, 900, RET, 901, 905);
  endtask : t_user_no_trap

  // ---------------------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    rst_n_i = 1'b0;
    issue = '0;
    cfg = '0;
    start = 1'b0;
    mode = 2'h0;
    delay = 10'h000;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_resv_break();
    t_irq_wake();
    t_early_exit();
    t_short_timeout();
    t_trap_machine();
    t_trap_virtual();
    t_trap_priority();
    t_machine_mode();
    t_user_no_trap();
    stop_test();
  end

  // about 4500 cycles expected; cut off well beyond that
  initial begin
    #60000;
    fail_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    stop_test();
  end
endmodule : wrs_stall_ctrl_tb_top

`default_nettype wire
